// >>> gxre_encoder.sv
// guest exit reason encoder: classifies exit causes into the exit-reason word
//
// Design decisions made here: the address map and the strobed register port.
module gxre_encoder (
    input wire logic i_clk,
    input wire logic i_rstn,
    // register port
    input wire logic [gxre_pkg::ADDR_W-1:0] i_addr,
    input wire logic [gxre_pkg::WORD_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [gxre_pkg::WORD_W-1:0] o_rdata,
    // core state
    input wire logic i_guest_active,
    input wire logic i_in_system_mgmt_mode,
    input wire logic i_insn_boundary,
    input wire logic i_irq_enable_flag,
    input wire logic i_set_irq_enable_shadow,
    input wire logic i_ss_shadow,
    input wire logic i_virt_nmi_blocked,
    input wire logic i_wait_startup,
    // events
    input wire logic i_evt_exception,
    input wire logic [gxre_pkg::VEC_W-1:0] i_exc_vector,
    input wire logic i_evt_dbl_fault_fault,
    input wire logic i_evt_nmi,
    input wire logic i_evt_ext_irq,
    input wire logic i_evt_init,
    input wire logic i_evt_startup_ipi,
    input wire logic i_evt_mgmt_irq,
    input wire logic i_mgmt_irq_after_io,
    input wire logic i_evt_task_switch,
    input wire gxre_pkg::gxre_insn_e i_insn_kind,
    input wire logic i_monitor_hv_call,
    input wire logic i_entry_fail,
    input wire logic [gxre_pkg::CODE_W-1:0] i_entry_fail_code,
    // write toward the control structure
    output logic o_ctl_struct_wr,
    output logic [gxre_pkg::WORD_W-1:0] o_ctl_struct_data
);
    import gxre_pkg::*;

    logic [CTRL_W-1:0] ctrl_r;
    logic [WORD_W-1:0] bitmap_r;
    logic [WORD_W-1:0] last_r;
    logic seen_r;
    logic fail_r;
    logic [CNT_W-1:0] cnt_r;
    logic wr_r;
    logic [WORD_W-1:0] data_r;
    logic [WORD_W-1:0] rdata_r;

    // register decode
    wire wr_ctrl = i_wr && (i_addr == OFS_CTRL);
    wire wr_bitmap = i_wr && (i_addr == OFS_EXC_BITMAP);
    wire wr_status = i_wr && (i_addr == OFS_STATUS);
    wire wr_count = i_wr && (i_addr == OFS_EXIT_COUNT);

    // guest-side causes; events outside guest mode do not exit
    wire g = i_guest_active;
    wire exc_bit = bitmap_r[i_exc_vector];
    // instruction faults arrive here as plain vectors, no special case
    wire hit_exc = g && i_evt_exception && exc_bit;
    wire hit_dbl = g && i_evt_dbl_fault_fault;
    wire hit_nmi = g && i_evt_nmi && ctrl_r[CTRL_NMI_EXIT];
    wire hit_ext = g && i_evt_ext_irq && ctrl_r[CTRL_EXT_IRQ_EXIT];
    wire hit_init = g && i_evt_init;
    wire hit_startup = g && i_evt_startup_ipi && i_wait_startup;
    wire hit_mgmt = g && i_evt_mgmt_irq;
    wire irq_win_open = i_insn_boundary && i_irq_enable_flag
        && !i_set_irq_enable_shadow && !i_ss_shadow;
    wire hit_irq_win = g && irq_win_open && ctrl_r[CTRL_IRQ_WIN_EXIT];
    wire nmi_win_open = i_insn_boundary && !i_virt_nmi_blocked && !i_ss_shadow;
    wire hit_nmi_win = g && nmi_win_open && ctrl_r[CTRL_NMI_WIN_EXIT];
    wire hit_task = g && i_evt_task_switch;

    // instruction decode into a code, gated by its control where one exists
    logic insn_hit;
    logic [CODE_W-1:0] insn_code;
    always_comb begin
        insn_hit = 1'b0;
        insn_code = CODE_EXC_NMI;
        case (i_insn_kind)
            INSN_IDENT_QUERY: begin
                insn_hit = 1'b1;
                insn_code = CODE_IDENT_QUERY;
            end
            INSN_SAFER_MODE: begin
                insn_hit = 1'b1;
                insn_code = CODE_SAFER_MODE;
            end
            INSN_CACHE_INV_NOWB: begin
                insn_hit = 1'b1;
                insn_code = CODE_CACHE_INV;
            end
            INSN_HALT: begin
                insn_hit = ctrl_r[CTRL_HALT_EXIT];
                insn_code = CODE_HALT;
            end
            INSN_PAGE_INV: begin
                insn_hit = ctrl_r[CTRL_PAGE_INV_EXIT];
                insn_code = CODE_PAGE_INV;
            end
            INSN_PERF_RD: begin
                insn_hit = ctrl_r[CTRL_PERF_RD_EXIT];
                insn_code = CODE_PERF_RD;
            end
            INSN_TS_RD: begin
                insn_hit = ctrl_r[CTRL_TS_RD_EXIT];
                insn_code = CODE_TS_RD;
            end
            INSN_MGMT_RESUME: begin
                insn_hit = i_in_system_mgmt_mode;
                insn_code = CODE_MGMT_RESUME;
            end
            INSN_HV_CALL: begin
                insn_hit = 1'b1;
                insn_code = CODE_HV_CALL;
            end
            INSN_STRUCT_CLEAR: begin
                insn_hit = 1'b1;
                insn_code = CODE_STRUCT_CLEAR;
            end
            INSN_GUEST_LAUNCH: begin
                insn_hit = 1'b1;
                insn_code = CODE_GUEST_LAUNCH;
            end
            INSN_PTR_LOAD: begin
                insn_hit = 1'b1;
                insn_code = CODE_PTR_LOAD;
            end
            INSN_PTR_STORE: begin
                insn_hit = 1'b1;
                insn_code = CODE_PTR_STORE;
            end
            default: begin
                insn_hit = 1'b0;
                insn_code = CODE_EXC_NMI;
            end
        endcase
    end

    // the monitor's call exits from management mode, not from the guest
    wire hit_insn = g && insn_hit;
    wire hit_mon = i_monitor_hv_call;

    // priority: init, mgmt irq, double fault, exception, nmi, ext irq,
    // startup ipi, nmi window, irq window, task switch, insn, monitor call.
    // only one cause is written per cycle; lower ones are dropped and must
    // be re-raised by the core once the guest is resumed
    wire [CODE_W-1:0] mgmt_code =
        i_mgmt_irq_after_io ? CODE_MGMT_IRQ_IO : CODE_MGMT_IRQ_OTHER;
    // an intercepted fault during double-fault delivery is an exception exit
    wire [CODE_W-1:0] dbl_code = exc_bit ? CODE_EXC_NMI : CODE_TRIPLE;
    wire [CODE_W-1:0] sel_code =
        hit_init ? CODE_INIT :
        hit_mgmt ? mgmt_code :
        hit_dbl ? dbl_code :
        hit_exc ? CODE_EXC_NMI :
        hit_nmi ? CODE_EXC_NMI :
        hit_ext ? CODE_EXT_IRQ :
        hit_startup ? CODE_STARTUP_IPI :
        hit_nmi_win ? CODE_NMI_WIN :
        hit_irq_win ? CODE_IRQ_WIN :
        hit_task ? CODE_TASK_SW :
        hit_insn ? insn_code :
        hit_mon ? CODE_HV_CALL :
        i_entry_fail_code;
    wire exit_any = hit_init || hit_mgmt || hit_dbl || hit_exc || hit_nmi || hit_ext
        || hit_startup || hit_nmi_win || hit_irq_win || hit_task || hit_insn || hit_mon;
    // entry failures cannot coincide with a guest exit; exits win if they do
    wire fail_only = i_entry_fail && !exit_any;
    wire rec = exit_any || i_entry_fail;
    wire [WORD_W-1:0] word_nxt = {UPPER_ZERO, sel_code};

    // control structure write, one cycle after the cause
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            wr_r <= 1'b0;
            data_r <= WORD_ZERO;
        end else begin
            wr_r <= rec;
            data_r <= rec ? word_nxt : data_r;
        end
    end

    // software controls that steer interception
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            ctrl_r <= CTRL_RST;
            bitmap_r <= BITMAP_RST;
        end else begin
            ctrl_r <= wr_ctrl ? i_wdata[CTRL_W-1:0] : ctrl_r;
            bitmap_r <= wr_bitmap ? i_wdata : bitmap_r;
        end
    end

    // status: sticky seen bit is write-one-to-clear, a new record wins
    wire seen_nxt = rec || (seen_r && !(wr_status && i_wdata[STAT_EXIT_SEEN]));
    // counter write clears it; an exit in the same cycle leaves it at one
    wire [CNT_W-1:0] cnt_nxt = wr_count ? (rec ? CNT_ONE : '0) :
        (rec ? cnt_r + CNT_ONE : cnt_r);
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            seen_r <= 1'b0;
            fail_r <= 1'b0;
            cnt_r <= '0;
            last_r <= WORD_ZERO;
        end else begin
            seen_r <= seen_nxt;
            fail_r <= rec ? fail_only : fail_r;
            cnt_r <= cnt_nxt;
            last_r <= rec ? word_nxt : last_r;
        end
    end

    // read mux; unmapped addresses read zero
    wire [WORD_W-1:0] stat_word = {{(WORD_W-2){1'b0}}, fail_r, seen_r};
    wire [WORD_W-1:0] rd_mux =
        (i_addr == OFS_CTRL) ? {{(WORD_W-CTRL_W){1'b0}}, ctrl_r} :
        (i_addr == OFS_EXC_BITMAP) ? bitmap_r :
        (i_addr == OFS_LAST_REASON) ? last_r :
        (i_addr == OFS_STATUS) ? stat_word :
        (i_addr == OFS_EXIT_COUNT) ? {{(WORD_W-CNT_W){1'b0}}, cnt_r} :
        WORD_ZERO;

    // read data valid only in the cycle after the strobe
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            rdata_r <= WORD_ZERO;
        end else begin
            rdata_r <= i_rd ? rd_mux : WORD_ZERO;
        end
    end

    assign o_rdata = rdata_r;
    assign o_ctl_struct_wr = wr_r;
    assign o_ctl_struct_data = data_r;

    // checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);

    // higher-ranked causes, helper logic for the checks only
    wire hi_exc = hit_init || hit_mgmt || hit_dbl;
    wire hi_ext = hi_exc || hit_exc || hit_nmi;
    wire hi_win = hi_ext || hit_ext || hit_startup;
    wire hi_insn = hi_win || hit_nmi_win || hit_irq_win || hit_task;
    wire only_insn = g && !hi_insn && !i_monitor_hv_call && !i_entry_fail;

    chk_upper_zero:
    assert property (o_ctl_struct_wr |-> o_ctl_struct_data[WORD_W-1:CODE_W] == UPPER_ZERO)
        else $error("upper half of exit word not zero");

    chk_exit_write:
    assert property (exit_any |=> o_ctl_struct_wr && o_ctl_struct_data == $past(word_nxt))
        else $error("exit not written next cycle");

    chk_fail_record:
    assert property (fail_only |=> o_ctl_struct_wr
        && o_ctl_struct_data[CODE_W-1:0] == $past(i_entry_fail_code))
        else $error("entry failure not recorded");

    chk_init_code:
    assert property (g && i_evt_init |=> o_ctl_struct_data[CODE_W-1:0] == CODE_INIT)
        else $error("init not reported as code 3");

    chk_mgmt_split:
    assert property (g && i_evt_mgmt_irq && !i_evt_init |=> o_ctl_struct_data[CODE_W-1:0]
        == ($past(i_mgmt_irq_after_io) ? CODE_MGMT_IRQ_IO : CODE_MGMT_IRQ_OTHER))
        else $error("management irq code wrong");

    chk_exc_bitmap:
    assert property (g && i_evt_exception && bitmap_r[i_exc_vector] && !i_evt_init
        && !i_evt_mgmt_irq |=> o_ctl_struct_wr && o_ctl_struct_data[CODE_W-1:0] == CODE_EXC_NMI)
        else $error("intercepted exception not code 0");

    chk_triple_code:
    assert property (hit_dbl && !hit_init && !hit_mgmt && !exc_bit |=>
        o_ctl_struct_data[CODE_W-1:0] == CODE_TRIPLE)
        else $error("triple fault not code 2");

    chk_halt_gate:
    assert property (g && i_insn_kind == INSN_HALT && !ctrl_r[CTRL_HALT_EXIT]
        && !exit_any && !i_entry_fail |=> !o_ctl_struct_wr)
        else $error("halt exit without control");

    chk_irq_window:
    assert property (hit_irq_win && !hi_win && !hit_nmi_win
        |=> o_ctl_struct_data[CODE_W-1:0] == CODE_IRQ_WIN)
        else $error("interrupt window code wrong");

    chk_nmi_code:
    assert property (hit_nmi && !hi_exc |=> o_ctl_struct_data[CODE_W-1:0] == CODE_EXC_NMI)
        else $error("nmi exit not code 0");

    chk_ext_code:
    assert property (hit_ext && !hi_ext |=> o_ctl_struct_data[CODE_W-1:0] == CODE_EXT_IRQ)
        else $error("external irq not code 1");

    chk_startup_code:
    assert property (hit_startup && !hi_ext && !hit_ext
        |=> o_ctl_struct_data[CODE_W-1:0] == CODE_STARTUP_IPI)
        else $error("startup ipi not code 4");

    chk_nmi_window:
    assert property (hit_nmi_win && !hi_win
        |=> o_ctl_struct_data[CODE_W-1:0] == CODE_NMI_WIN)
        else $error("nmi window code wrong");

    chk_task_code:
    assert property (hit_task && !hi_win && !hit_nmi_win && !hit_irq_win
        |=> o_ctl_struct_data[CODE_W-1:0] == CODE_TASK_SW)
        else $error("task switch not code 9");

    chk_ident_code:
    assert property (g && !hi_insn && i_insn_kind == INSN_IDENT_QUERY
        |=> o_ctl_struct_wr && o_ctl_struct_data[CODE_W-1:0] == CODE_IDENT_QUERY)
        else $error("identification query not code 10");

    chk_launch_code:
    assert property (g && !hi_insn && i_insn_kind == INSN_GUEST_LAUNCH
        |=> o_ctl_struct_wr && o_ctl_struct_data[CODE_W-1:0] == CODE_GUEST_LAUNCH)
        else $error("guest launch not code 20");

    chk_page_inv_gate:
    assert property (only_insn && i_insn_kind == INSN_PAGE_INV
        |=> o_ctl_struct_wr == $past(ctrl_r[CTRL_PAGE_INV_EXIT]))
        else $error("page invalidate gate wrong");

    chk_perf_rd_gate:
    assert property (only_insn && i_insn_kind == INSN_PERF_RD
        |=> o_ctl_struct_wr == $past(ctrl_r[CTRL_PERF_RD_EXIT]))
        else $error("performance read gate wrong");

    chk_ts_rd_gate:
    assert property (only_insn && i_insn_kind == INSN_TS_RD
        |=> o_ctl_struct_wr == $past(ctrl_r[CTRL_TS_RD_EXIT]))
        else $error("timestamp read gate wrong");

    chk_resume_gate:
    assert property (only_insn && i_insn_kind == INSN_MGMT_RESUME
        |=> o_ctl_struct_wr == $past(i_in_system_mgmt_mode))
        else $error("management resume gate wrong");

    chk_monitor_call:
    assert property (hit_mon && !hi_insn && !hit_insn
        |=> o_ctl_struct_data[CODE_W-1:0] == CODE_HV_CALL)
        else $error("monitor call not code 18");

    chk_count_step:
    assert property (rec && !wr_count |=> cnt_r == $past(cnt_r) + CNT_ONE)
        else $error("exit count did not step");
endmodule

// >>> gxre_pkg.sv
// constants, codes and register map for the guest exit reason encoder
package gxre_pkg;
    // word layout
    localparam int WORD_W = 32;
    localparam int CODE_W = 16;
    localparam int VEC_W = 5;
    localparam int ADDR_W = 8;
    localparam int CNT_W = 16;

    // basic exit reason codes
    localparam logic [15:0] CODE_EXC_NMI = 16'h0000;
    localparam logic [15:0] CODE_EXT_IRQ = 16'h0001;
    localparam logic [15:0] CODE_TRIPLE = 16'h0002;
    localparam logic [15:0] CODE_INIT = 16'h0003;
    localparam logic [15:0] CODE_STARTUP_IPI = 16'h0004;
    localparam logic [15:0] CODE_MGMT_IRQ_IO = 16'h0005;
    localparam logic [15:0] CODE_MGMT_IRQ_OTHER = 16'h0006;
    localparam logic [15:0] CODE_IRQ_WIN = 16'h0007;
    localparam logic [15:0] CODE_NMI_WIN = 16'h0008;
    localparam logic [15:0] CODE_TASK_SW = 16'h0009;
    localparam logic [15:0] CODE_IDENT_QUERY = 16'h000A;
    localparam logic [15:0] CODE_SAFER_MODE = 16'h000B;
    localparam logic [15:0] CODE_HALT = 16'h000C;
    localparam logic [15:0] CODE_CACHE_INV = 16'h000D;
    localparam logic [15:0] CODE_PAGE_INV = 16'h000E;
    localparam logic [15:0] CODE_PERF_RD = 16'h000F;
    localparam logic [15:0] CODE_TS_RD = 16'h0010;
    localparam logic [15:0] CODE_MGMT_RESUME = 16'h0011;
    localparam logic [15:0] CODE_HV_CALL = 16'h0012;
    localparam logic [15:0] CODE_STRUCT_CLEAR = 16'h0013;
    localparam logic [15:0] CODE_GUEST_LAUNCH = 16'h0014;
    localparam logic [15:0] CODE_PTR_LOAD = 16'h0015;
    localparam logic [15:0] CODE_PTR_STORE = 16'h0016;
    localparam logic [15:0] UPPER_ZERO = 16'h0000;

    // register offsets (byte addresses)
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_EXC_BITMAP = 8'h04;
    localparam logic [7:0] OFS_LAST_REASON = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0C;
    localparam logic [7:0] OFS_EXIT_COUNT = 8'h10;

    // control register bit positions
    localparam int CTRL_NMI_EXIT = 0;
    localparam int CTRL_EXT_IRQ_EXIT = 1;
    localparam int CTRL_IRQ_WIN_EXIT = 2;
    localparam int CTRL_NMI_WIN_EXIT = 3;
    localparam int CTRL_HALT_EXIT = 4;
    localparam int CTRL_PAGE_INV_EXIT = 5;
    localparam int CTRL_PERF_RD_EXIT = 6;
    localparam int CTRL_TS_RD_EXIT = 7;
    localparam int CTRL_W = 8;

    // status register bit positions
    localparam int STAT_EXIT_SEEN = 0;
    localparam int STAT_ENTRY_FAIL = 1;

    // reset values and the counter step
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [31:0] BITMAP_RST = 32'h0000_0000;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
    localparam logic [15:0] CNT_ONE = 16'h0001;

    // decoded instruction kind from the core
    typedef enum logic [3:0] {
        INSN_NONE,
        INSN_IDENT_QUERY,
        INSN_SAFER_MODE,
        INSN_HALT,
        INSN_CACHE_INV_NOWB,
        INSN_PAGE_INV,
        INSN_PERF_RD,
        INSN_TS_RD,
        INSN_MGMT_RESUME,
        INSN_HV_CALL,
        INSN_STRUCT_CLEAR,
        INSN_GUEST_LAUNCH,
        INSN_PTR_LOAD,
        INSN_PTR_STORE
    } gxre_insn_e;
endpackage

// >>> gxre_core_model.sv
// core-side model: turns one cause request into one-cycle event pulses
module gxre_core_model (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_go,
    input wire logic [3:0] i_cause,
    input wire logic [4:0] i_vec,
    input wire gxre_pkg::gxre_insn_e i_insn,
    input wire logic i_io,
    input wire logic [15:0] i_code,
    output logic o_exc,
    output logic o_dbl,
    output logic o_nmi,
    output logic o_ext,
    output logic o_init,
    output logic o_sup,
    output logic o_mgmt,
    output logic o_task,
    output logic o_mon,
    output logic o_fail,
    output logic o_bnd,
    output gxre_pkg::gxre_insn_e o_insn,
    output logic [4:0] o_vec,
    output logic o_io,
    output logic [15:0] o_code
);
    timeunit 1ns;
    timeprecision 1ps;
    import gxre_pkg::*;
    logic [11:0] hit;
    // one-hot decode of the requested cause
    assign hit = i_go ? (12'h001 << i_cause) : 12'h000;
    // pulses last one cycle; faulting trap insns share the exception path
    always_ff @(posedge i_clk) begin
        {o_bnd, o_fail, o_mon, o_task, o_mgmt, o_sup, o_init, o_ext, o_nmi, o_dbl, o_exc} <=
            {hit[11:9], hit[7:0]};
        o_insn <= hit[8] ? i_insn : INSN_NONE;
    end
    // released qualifiers flip each cycle so a stale value never looks valid
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            o_vec <= 5'h00;
            o_io <= 1'b0;
            o_code <= 16'h0000;
        end else if (i_go) begin
            o_vec <= i_vec;
            o_io <= i_io;
            o_code <= i_code;
        end else begin
            o_vec <= ~o_vec;
            o_io <= ~o_io;
            o_code <= ~o_code;
        end
    end
endmodule

// >>> gxre_encoder_tb.sv
// self-checking bench for the guest exit reason encoder
module gxre_encoder_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import gxre_pkg::*;
    logic i_clk, i_rstn, i_wr, i_rd, i_guest_active, in_mm, i_irq_enable_flag, ie_shd, seg_shd;
    logic i_virt_nmi_blocked, i_wait_startup, go, io, last_fail, o_ctl_struct_wr;
    logic i_evt_exception, i_evt_dbl_fault_fault, i_evt_nmi, i_evt_ext_irq, i_evt_init, e_sup;
    logic i_evt_mgmt_irq, i_evt_task_switch, i_monitor_hv_call, i_entry_fail, i_insn_boundary;
    logic i_mgmt_irq_after_io;
    logic [3:0] cause;
    logic [4:0] vec, i_exc_vector;
    logic [7:0] i_addr, ctrl_v;
    logic [15:0] code, i_entry_fail_code;
    logic [31:0] i_wdata, o_rdata, o_ctl_struct_data, seed, bm_v, last_w, d;
    gxre_insn_e insn, i_insn_kind;
    int err_count, samples_checked, exp_cnt;

    gxre_encoder i_gxre_encoder (
        .i_clk, .i_rstn, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_guest_active,
        .i_in_system_mgmt_mode(in_mm), .i_insn_boundary, .i_irq_enable_flag,
        .i_set_irq_enable_shadow(ie_shd), .i_ss_shadow(seg_shd), .i_virt_nmi_blocked,
        .i_wait_startup, .i_evt_exception,
        .i_exc_vector, .i_evt_dbl_fault_fault, .i_evt_nmi, .i_evt_ext_irq, .i_evt_init,
        .i_evt_startup_ipi(e_sup), .i_evt_mgmt_irq, .i_mgmt_irq_after_io, .i_evt_task_switch,
        .i_insn_kind, .i_monitor_hv_call, .i_entry_fail, .i_entry_fail_code,
        .o_ctl_struct_wr, .o_ctl_struct_data
    );
    gxre_core_model i_gxre_core_model (
        .i_clk, .i_rstn, .i_go(go), .i_cause(cause), .i_vec(vec), .i_insn(insn), .i_io(io),
        .i_code(code), .o_exc(i_evt_exception), .o_dbl(i_evt_dbl_fault_fault),
        .o_nmi(i_evt_nmi), .o_ext(i_evt_ext_irq), .o_init(i_evt_init), .o_sup(e_sup),
        .o_mgmt(i_evt_mgmt_irq), .o_task(i_evt_task_switch), .o_mon(i_monitor_hv_call),
        .o_fail(i_entry_fail), .o_bnd(i_insn_boundary), .o_insn(i_insn_kind),
        .o_vec(i_exc_vector), .o_io(i_mgmt_irq_after_io), .o_code(i_entry_fail_code)
    );

    // 100 MHz clock
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    // expected {write, code}; window 8 outranks window 7
    function automatic logic [16:0] expect_rec(input logic [3:0] c, input logic [4:0] v,
            input gxre_insn_e n, input logic o, input logic [15:0] k, input logic [2:0] s);
        logic [16:0] r;
        logic nw;
        nw = ctrl_v[3] && !i_virt_nmi_blocked && !s[0];
        case (c)
            4'h0: r = {bm_v[v], 16'h0000};
            4'h1: r = {1'b1, (bm_v[v] ? 16'h0000 : 16'h0002)};
            4'h2: r = {ctrl_v[0], 16'h0000};
            4'h3: r = {ctrl_v[1], 16'h0001};
            4'h4: r = {1'b1, 16'h0003};
            4'h5: r = {i_wait_startup, 16'h0004};
            4'h6: r = {1'b1, (o ? 16'h0005 : 16'h0006)};
            4'h7: r = {1'b1, 16'h0009};
            4'h9: r = {1'b1, 16'h0012};
            4'ha: r = {1'b1, k};
            4'hb: r = nw ? {1'b1, 16'h0008} : {ctrl_v[2] && s[2] && !s[1] && !s[0], 16'h0007};
            default: begin
                case (n)
                    INSN_HALT: r = {ctrl_v[4], 16'h000c};
                    INSN_CACHE_INV_NOWB: r = {1'b1, 16'h000d};
                    INSN_PAGE_INV: r = {ctrl_v[5], 16'h000e};
                    INSN_PERF_RD: r = {ctrl_v[6], 16'h000f};
                    INSN_TS_RD: r = {ctrl_v[7], 16'h0010};
                    INSN_MGMT_RESUME: r = {in_mm, 16'h0011};
                    INSN_HV_CALL: r = {1'b1, 16'h0012};
                    default: r = {1'b1, 12'h000, n} + (n < 4'h4 ? 17'h0_0009 : 17'h0_0009);
                endcase
            end
        endcase
        // only the monitor call and entry failure bypass the guest gate
        r[16] = r[16] && (i_guest_active || c == 4'h9 || c == 4'ha);
        return r;
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_sim;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
        @(posedge i_clk);
        i_addr <= a;
        i_wdata <= v;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
        @(posedge i_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        @(negedge i_clk);
        v = o_rdata;
        @(negedge i_clk);
        check(o_rdata, 32'h0000_0000);
    endtask

    // one cause with random vector, qualifier and code; bounded look for the write
    task automatic fire(input logic [3:0] c, input gxre_insn_e n);
        logic [16:0] r;
        logic [31:0] exp_w, hit, ew;
        logic [2:0] sh;
        @(posedge i_clk);
        seed = xs(seed);
        // {irq flag, enable shadow, stack shadow}: half open windows, half random
        sh = seed[9] ? 3'b100 : seed[8:6];
        r = expect_rec(c, seed[4:0], n, seed[5], seed[31:16], sh);
        exp_w = {16'h0000, r[15:0]};
        ew = {31'h0000_0000, r[16]};
        go <= 1'b1;
        cause <= c;
        insn <= n;
        vec <= seed[4:0];
        io <= seed[5];
        code <= seed[31:16];
        {i_irq_enable_flag, ie_shd, seg_shd} <= sh;
        @(posedge i_clk);
        go <= 1'b0;
        hit = 32'h0000_0000;
        repeat (4) begin
            @(negedge i_clk);
            if (o_ctl_struct_wr === 1'b1) begin
                hit++;
                check(o_ctl_struct_data, exp_w);
            end
        end
        check(hit, ew);
        if (r[16]) begin
            exp_cnt++;
            last_w = exp_w;
            last_fail = (c == 4'ha);
        end
    endtask

    // reset, register defaults, then four passes over every cause
    initial begin
        {i_rstn, i_wr, i_rd, go, io, in_mm, ie_shd, seg_shd} = '0;
        {i_guest_active, i_virt_nmi_blocked, i_wait_startup, last_fail} = '0;
        i_irq_enable_flag = 1'b1;
        i_addr = 8'h00;
        i_wdata = 32'h0000_0000;
        {cause, vec, code} = '0;
        insn = INSN_NONE;
        seed = 32'h0000_4e57;
        {err_count, samples_checked, exp_cnt} = '0;
        repeat (12) @(posedge i_clk);
        i_rstn <= 1'b1;
        check(o_ctl_struct_data, 32'h0000_0000);
        for (int a = 0; a < 6; a++) begin
            rd_reg(8'(a * 4), d);
            check(d, 32'h0000_0000);
        end
        $display("test reset done");
        for (int p = 0; p < 4; p++) begin
            seed = xs(seed);
            bm_v = seed;
            ctrl_v = (p == 1) ? 8'h00 : 8'hff;
            wr_reg(OFS_CTRL, {24'h00_0000, ctrl_v});
            wr_reg(OFS_EXC_BITMAP, bm_v);
            rd_reg(OFS_CTRL, d);
            check(d, {24'h00_0000, ctrl_v});
            rd_reg(OFS_EXC_BITMAP, d);
            check(d, bm_v);
            @(posedge i_clk);
            i_guest_active <= (p != 3);
            in_mm <= (p != 1);
            i_wait_startup <= (p != 1);
            i_virt_nmi_blocked <= (p == 2);
            for (int c = 0; c < 12; c++) begin
                if (c == 8) begin
                    for (int n = 1; n < 14; n++) fire(4'h8, gxre_insn_e'(n));
                end else begin
                    repeat (3) fire(4'(c), INSN_NONE);
                end
            end
            $display("test pass %0d done", p);
        end
        rd_reg(OFS_LAST_REASON, d);
        check(d, last_w);
        wr_reg(OFS_LAST_REASON, 32'hffff_ffff);
        rd_reg(OFS_LAST_REASON, d);
        check(d, last_w);
        rd_reg(OFS_EXIT_COUNT, d);
        check(d, 32'(exp_cnt));
        rd_reg(OFS_STATUS, d);
        check(d, {30'h0, last_fail, 1'b1});
        wr_reg(OFS_STATUS, 32'h0000_0001);
        rd_reg(OFS_STATUS, d);
        check(d, {30'h0, last_fail, 1'b0});
        wr_reg(OFS_EXIT_COUNT, 32'h0000_0000);
        rd_reg(OFS_EXIT_COUNT, d);
        check(d, 32'h0000_0000);
        $display("test registers done");
        end_sim;
    end
endmodule
